// ### hdl/dtbc_pkg.sv
// Constants for the dead-time blanking commutator.
// Assumes a 40 MHz system clock from which the blanking oscillator tick is divided.
// Function
// - Blanking acts only with blanking enable high
// - Oscillator tick clocks only the delay line
// - Polarity passes three-stage tick-clocked delay line
// - With blanking enabled, outputs enabled only while all stages agree
// - Polarity change blanks outputs two tick periods
// - Blanking start may lag up to one period
// - Polarity change reverses every sink and source
// - Phasing select high decodes 30-degree Hall phasing
// - Tied b and c leave four position states
package dtbc_pkg;
    localparam int CLK_FREQ_MHZ  = 40;
    // Period of the blanking oscillator; two periods must exceed switch turn-off
    localparam int OSC_PERIOD_NS = 2400;
    localparam int OSC_CYCLES    = (OSC_PERIOD_NS * CLK_FREQ_MHZ) / 1000;
    localparam int SYNC_STAGES   = 3;
    localparam int DELAY_STAGES  = 3;
    localparam int PHASES        = 3;
    localparam logic [2:0] DRIVE_OFF = 3'h0;
    localparam logic [2:0] DRIVE_P1  = 3'h1;
    localparam logic [2:0] DRIVE_P2  = 3'h2;
    localparam logic [2:0] DRIVE_P3  = 3'h4;
endpackage : dtbc_pkg

// ### hdl/dtbc_sync.sv
// Three-flop input synchroniser with agreement filter, one per bit.
// Assumes asynchronous inputs; output changes once flops two and three agree.
`timescale 1ns/10ps
module dtbc_sync
    import dtbc_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             rstn_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    typedef struct packed {
        logic [WIDTH-1:0] ff1;
        logic [WIDTH-1:0] ff2;
        logic [WIDTH-1:0] ff3;
        logic [WIDTH-1:0] out;
    } dtbc_sync_st_t;

    dtbc_sync_st_t s_r;
    dtbc_sync_st_t s_nxt;

    always_comb begin
        s_nxt     = s_r;
        s_nxt.ff1 = async_i;
        s_nxt.ff2 = s_r.ff1;
        s_nxt.ff3 = s_r.ff2;
        for (int i = 0; i < WIDTH; i++) begin
            if (s_r.ff2[i] == s_r.ff3[i]) begin
                s_nxt.out[i] = s_r.ff3[i];
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sync_o = s_r.out;

    property p_sync_agree;
        @(posedge clk_i) disable iff (!rstn_i)
        (s_r.ff2 != s_r.out) && (s_r.ff2 == s_r.ff3) |=> (sync_o == $past(s_r.ff3));
    endproperty
    a_sync_agree: assert property (p_sync_agree) else $error("sync output missed agreed value");
endmodule : dtbc_sync

// ### hdl/dtbc_commutator.sv
// Dead-time blanking commutator: Hall decode, polarity delay line, output gating.
// Assumes asynchronous pins; drive outputs go to external power switches.
`timescale 1ns/10ps
module dtbc_commutator
    import dtbc_pkg::*;
#(
    parameter int OSC_DIV = OSC_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic        polarity_i,
    input  wire logic        blank_en_i,
    input  wire logic        phase30_sel_i,
    input  wire logic        hall_in_a_i,
    input  wire logic        hall_in_b_i,
    input  wire logic        hall_in_c_i,
    output logic      [2:0]  sink_o,
    output logic      [2:0]  source_o
);
    localparam int DIV_W = $clog2(OSC_DIV + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_DIV - 1);
    // Helper count for the dead-time check; saturates at two tick periods
    localparam int               BLANK_MIN = 2 * OSC_DIV;
    localparam int               CNT_W     = $clog2(BLANK_MIN + 1);
    localparam logic [CNT_W-1:0] CNT_LAST  = CNT_W'(BLANK_MIN);

    typedef struct packed {
        logic [DIV_W-1:0] div_cnt;
        logic             tick;
        logic [CNT_W-1:0] blank_cnt;
        logic             delay_stage_a;
        logic             delay_stage_b;
        logic             delay_stage_c;
        logic [2:0]       sink;
        logic [2:0]       source;
    } dtbc_state_t;

    dtbc_state_t s_r;
    dtbc_state_t s_nxt;

    logic [5:0] pins_sync;
    logic       pol_s;
    logic       blank_en_s;
    logic       phase30_s;
    logic [2:0] hall_s;
    logic       agree_gate_a;
    logic       agree_gate_b;
    logic       agree;
    logic       drive_pol;
    logic [2:0] dec_sink;
    logic [2:0] dec_source;

    // Lag of the synchroniser plus tick phase gives the blanking start jitter
    dtbc_sync #(
        .WIDTH (6)
    ) u_sync (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .async_i ({polarity_i, blank_en_i, phase30_sel_i,
                   hall_in_a_i, hall_in_b_i, hall_in_c_i}),
        .sync_o  (pins_sync)
    );

    assign pol_s      = pins_sync[5];
    assign blank_en_s = pins_sync[4];
    assign phase30_s  = pins_sync[3];
    assign hall_s     = pins_sync[2:0];

    // Both gates need all three stages equal
    assign agree_gate_a = s_r.delay_stage_a & s_r.delay_stage_b & s_r.delay_stage_c;
    assign agree_gate_b = ~(s_r.delay_stage_a | s_r.delay_stage_b | s_r.delay_stage_c);
    assign agree        = agree_gate_a | agree_gate_b;

    // Without blanking the polarity goes straight through
    assign drive_pol = blank_en_s ? s_r.delay_stage_c : pol_s;

    // Position decode; hall_s = {a, b, c}. With b tied to c only four codes occur
    always_comb begin
        dec_sink   = DRIVE_OFF;
        dec_source = DRIVE_OFF;
        if (phase30_s) begin
            unique case (hall_s)
                3'h0: begin dec_sink = DRIVE_P1; dec_source = DRIVE_P2; end
                3'h1: begin dec_sink = DRIVE_P1; dec_source = DRIVE_P3; end
                3'h3: begin dec_sink = DRIVE_P2; dec_source = DRIVE_P3; end
                3'h7: begin dec_sink = DRIVE_P2; dec_source = DRIVE_P1; end
                3'h6: begin dec_sink = DRIVE_P3; dec_source = DRIVE_P1; end
                3'h4: begin dec_sink = DRIVE_P3; dec_source = DRIVE_P2; end
                default: begin dec_sink = DRIVE_OFF; dec_source = DRIVE_OFF; end
            endcase
        end else begin
            unique case (hall_s)
                3'h5: begin dec_sink = DRIVE_P1; dec_source = DRIVE_P2; end
                3'h4: begin dec_sink = DRIVE_P1; dec_source = DRIVE_P3; end
                3'h6: begin dec_sink = DRIVE_P2; dec_source = DRIVE_P3; end
                3'h2: begin dec_sink = DRIVE_P2; dec_source = DRIVE_P1; end
                3'h3: begin dec_sink = DRIVE_P3; dec_source = DRIVE_P1; end
                3'h1: begin dec_sink = DRIVE_P3; dec_source = DRIVE_P2; end
                default: begin dec_sink = DRIVE_OFF; dec_source = DRIVE_OFF; end
            endcase
        end
    end

    always_comb begin
        s_nxt      = s_r;
        s_nxt.tick = 1'b0;
        // Tick divider stands in for the adjustable oscillator
        if (s_r.div_cnt == DIV_LAST) begin
            s_nxt.div_cnt = '0;
            s_nxt.tick    = 1'b1;
        end else begin
            s_nxt.div_cnt = s_r.div_cnt + DIV_W'(1);
        end
        // Only the delay line moves on the tick
        if (s_r.tick) begin
            s_nxt.delay_stage_a = pol_s;
            s_nxt.delay_stage_b = s_r.delay_stage_a;
            s_nxt.delay_stage_c = s_r.delay_stage_b;
        end
        // Outputs follow decode every clock, gated by agreement while blanking is enabled
        if (blank_en_s && !agree) begin
            s_nxt.sink   = DRIVE_OFF;
            s_nxt.source = DRIVE_OFF;
        end else if (drive_pol) begin
            s_nxt.sink   = dec_sink;
            s_nxt.source = dec_source;
        end else begin // Reversal swaps sink and source
            s_nxt.sink   = dec_source;
            s_nxt.source = dec_sink;
        end
        // Counts disagreement cycles; a short pulse can only lengthen it
        if (agree) begin
            s_nxt.blank_cnt = '0;
        end else if (s_r.blank_cnt != CNT_LAST) begin
            s_nxt.blank_cnt = s_r.blank_cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sink_o   = s_r.sink;
    assign source_o = s_r.source;

    property p_gate_off;
        @(posedge clk_i) disable iff (!rstn_i)
        blank_en_s && !agree |=> (sink_o == DRIVE_OFF) && (source_o == DRIVE_OFF);
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("outputs on during disagreement");

    property p_shift;
        @(posedge clk_i) disable iff (!rstn_i)
        s_r.tick |=> (s_r.delay_stage_b == $past(s_r.delay_stage_a))
                  && (s_r.delay_stage_c == $past(s_r.delay_stage_b))
                  && (s_r.delay_stage_a == $past(pol_s));
    endproperty
    a_shift: assert property (p_shift) else $error("delay line did not shift");

    property p_hold;
        @(posedge clk_i) disable iff (!rstn_i)
        !s_r.tick |=> $stable({s_r.delay_stage_a, s_r.delay_stage_b, s_r.delay_stage_c});
    endproperty
    a_hold: assert property (p_hold) else $error("delay line moved without tick");

    property p_blank_len;
        @(posedge clk_i) disable iff (!rstn_i)
        blank_en_s && s_r.tick && (pol_s != s_r.delay_stage_a)
        && (s_r.delay_stage_a == s_r.delay_stage_b)
        && (s_r.delay_stage_b == s_r.delay_stage_c)
        |=> !agree [*2];
    endproperty
    a_blank_len: assert property (p_blank_len) else $error("blanking too short");

    property p_bypass;
        @(posedge clk_i) disable iff (!rstn_i)
        !blank_en_s && pol_s |=> (sink_o == $past(dec_sink)) && (source_o == $past(dec_source));
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass did not pass decode");

    property p_reverse;
        @(posedge clk_i) disable iff (!rstn_i)
        !blank_en_s && !pol_s |=> (sink_o == $past(dec_source)) && (source_o == $past(dec_sink));
    endproperty
    a_reverse: assert property (p_reverse) else $error("reversal did not swap drives");

    property p_dec30;
        @(posedge clk_i) disable iff (!rstn_i)
        phase30_s && (hall_s == 3'h0) && drive_pol && (!blank_en_s || agree)
        |=> (sink_o == DRIVE_P1) && (source_o == DRIVE_P2);
    endproperty
    a_dec30: assert property (p_dec30) else $error("30-degree decode wrong");

    // Decode and swap never pair a sink and source on one phase
    property p_no_shoot;
        @(posedge clk_i) disable iff (!rstn_i)
        (sink_o & source_o) == DRIVE_OFF;
    endproperty
    a_no_shoot: assert property (p_no_shoot) else $error("sink and source on same phase");

    property p_agree_on;
        @(posedge clk_i) disable iff (!rstn_i)
        blank_en_s && agree |=> ((sink_o | source_o) == ($past(dec_sink) | $past(dec_source)));
    endproperty
    a_agree_on: assert property (p_agree_on) else $error("outputs off in agreement");

    property p_blank_min;
        @(posedge clk_i) disable iff (!rstn_i)
        !agree ##1 agree |-> (s_r.blank_cnt == CNT_LAST);
    endproperty
    a_blank_min: assert property (p_blank_min) else $error("dead time too short");

    // Quadrature wiring under 30-degree phasing must always land on a drivable code
    property p_quad_states;
        @(posedge clk_i) disable iff (!rstn_i)
        phase30_s && (hall_s[1] == hall_s[0]) |-> (dec_sink != DRIVE_OFF) && (dec_source != DRIVE_OFF);
    endproperty
    a_quad_states: assert property (p_quad_states) else $error("tied code undecoded");

    property p_tick_period;
        @(posedge clk_i) disable iff (!rstn_i)
        s_r.tick |=> !s_r.tick;
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("tick wider than one cycle");
endmodule : dtbc_commutator

// ### testbench/dtbc_far_model.sv
// Partner model: Hall sensors and the external power switches.
// Assumes the bench sets sensor levels; four-phase drives come from phases 1 and 3.
`timescale 1ns/10ps
module dtbc_far_model (
    input  wire logic       quad_mode_i,
    input  wire logic [2:0] hall_set_i,
    input  wire logic [2:0] sink_i,
    input  wire logic [2:0] source_i,
    output logic            hall_a_o,
    output logic            hall_b_o,
    output logic            hall_c_o,
    output logic      [3:0] sink4_o,
    output logic      [3:0] source4_o
);
    assign hall_a_o = hall_set_i[2];
    assign hall_b_o = hall_set_i[1];
    // Quadrature sensor has no third line, so b feeds both inputs
    assign hall_c_o = quad_mode_i ? hall_set_i[1] : hall_set_i[0];
    // Phase two unused; the inverses supply the other two windings
    assign sink4_o   = {~sink_i[2], sink_i[2], ~sink_i[0], sink_i[0]};
    assign source4_o = {~source_i[2], source_i[2], ~source_i[0], source_i[0]};
endmodule : dtbc_far_model

// ### testbench/dead_time_blanking_commutator_bench.sv
// Self-checking bench for the commutator with its Hall and switch partner.
// Assumes OSC_DIV shortened to 4 so the dead time spans 8 clocks.
`timescale 1ns/10ps
module dead_time_blanking_commutator_bench;
    import dtbc_pkg::*;
    // Short tick; real integrators size two periods above switch turn-off
    localparam int DIV = 4;
    logic       clk_i         = 1'b0;
    logic       rstn_i        = 1'b0;
    logic       polarity_i    = 1'b1;
    logic       blank_en_i    = 1'b1;
    logic       phase30_sel_i = 1'b1;
    logic       quad_mode     = 1'b0;
    logic [2:0] hall_set      = 3'h0;
    logic       ha;
    logic       hb;
    logic       hc;
    logic [2:0] sink_o;
    logic [2:0] source_o;
    logic [3:0] sink4;
    logic [3:0] source4;
    int         n_fail        = 0;
    int         check_count   = 0;
    always #12.5 clk_i = ~clk_i;
    dtbc_commutator #(.OSC_DIV(DIV)) dtbc_commutator_i (
        .clk_i(clk_i), .rstn_i(rstn_i), .polarity_i(polarity_i),
        .blank_en_i(blank_en_i), .phase30_sel_i(phase30_sel_i),
        .hall_in_a_i(ha), .hall_in_b_i(hb), .hall_in_c_i(hc),
        .sink_o(sink_o), .source_o(source_o));
    dtbc_far_model dtbc_far_model_i (
        .quad_mode_i(quad_mode), .hall_set_i(hall_set), .sink_i(sink_o),
        .source_i(source_o), .hall_a_o(ha), .hall_b_o(hb), .hall_c_o(hc),
        .sink4_o(sink4), .source4_o(source4));
    task automatic complete_run;
        $display("checks=%0d mismatches=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [5:0] exp30(input logic [2:0] c, input logic pol);
        logic [5:0] e;
        case (c)
            3'h0: e = {3'h1, 3'h2};
            3'h1: e = {3'h1, 3'h4};
            3'h3: e = {3'h2, 3'h4};
            3'h7: e = {3'h2, 3'h1};
            3'h6: e = {3'h4, 3'h1};
            3'h4: e = {3'h4, 3'h2};
            default: e = 6'h00;
        endcase
        return pol ? e : {e[2:0], e[5:3]};
    endfunction : exp30
    function automatic logic [5:0] exp60(input logic [2:0] c);
        logic [5:0] e;
        case (c)
            3'h5: e = {3'h1, 3'h2};
            3'h4: e = {3'h1, 3'h4};
            3'h6: e = {3'h2, 3'h4};
            3'h2: e = {3'h2, 3'h1};
            3'h3: e = {3'h4, 3'h1};
            3'h1: e = {3'h4, 3'h2};
            default: e = 6'h00;
        endcase
        return e;
    endfunction : exp60
    task automatic settle(input int n);
        repeat (n) @(negedge clk_i);
    endtask : settle
    task automatic t_decode30;
        for (int p = 0; p < 2; p++) begin
            for (int c = 0; c < 8; c++) begin
                polarity_i = p[0];
                hall_set = c[2:0];
                settle(24);
                chk({2'h0, sink_o, source_o}, {2'h0, exp30(c[2:0], p[0])});
            end
        end
    endtask : t_decode30
    task automatic t_reverse(input logic en);
        int lag;
        int len;
        lag = 0;
        len = 0;
        blank_en_i = en;
        polarity_i = 1'b1;
        hall_set = 3'h0;
        settle(24);
        polarity_i = 1'b0;
        while ({sink_o, source_o} === exp30(3'h0, 1'b1) && lag < 40) begin
            settle(1);
            lag++;
        end
        while ({sink_o, source_o} === 6'h00 && len < 40) begin
            settle(1);
            len++;
        end
        chk({7'h0, lag <= SYNC_STAGES + (en ? DIV : 0) + 2}, 8'h01);
        chk(len[7:0], en ? 8'(2 * DIV) : 8'h00);
        settle(2);
        chk({2'h0, sink_o, source_o}, {2'h0, exp30(3'h0, 1'b0)});
    endtask : t_reverse
    task automatic t_decode60;
        phase30_sel_i = 1'b0;
        polarity_i = 1'b1;
        for (int c = 0; c < 8; c++) begin
            hall_set = c[2:0];
            settle(12);
            chk({2'h0, sink_o, source_o}, {2'h0, exp60(c[2:0])});
        end
    endtask : t_decode60
    task automatic t_quad;
        logic [1:0] q [4] = '{2'h1, 2'h0, 2'h2, 2'h3};
        logic [5:0] e;
        polarity_i = 1'b1;
        quad_mode = 1'b1;
        phase30_sel_i = 1'b1;
        settle(24);
        foreach (q[i]) begin
            hall_set = {q[i], 1'b0};
            settle(12);
            e = exp30({q[i], q[i][0]}, 1'b1);
            chk({2'h0, sink_o, source_o}, {2'h0, e});
            chk({sink4, source4}, {~e[5], e[5], ~e[3], e[3], ~e[2], e[2], ~e[0], e[0]});
        end
    endtask : t_quad
    initial begin
        settle(20);
        chk({2'h0, sink_o, source_o}, 8'h00);
        rstn_i = 1'b1;
        t_decode30();
        t_reverse(1'b1);
        t_reverse(1'b0);
        t_decode60();
        t_quad();
        complete_run();
    end
    initial begin
        #(25 * 4000);
        n_fail++;
        complete_run();
    end
endmodule : dead_time_blanking_commutator_bench
